// file: rtl/spm_top.sv
// Purpose: speed and period measurement core with AXI4-Lite registers
// Assumes: 20 MHz aclk, pins asynchronous, bus master offers aw and w together
// Notes:   staged limits, output function and window apply on load commands
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps

module spm_top import spm_pkg::*; #(
  parameter int BASE_CYC = BASE_CYCLES  // cycles per 10 ms unit
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address and data
  input  wire logic [5:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read address and data
  input  wire logic [5:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // field pins
  input  wire logic        count_in,
  input  wire logic        gate_capable_input,
  input  wire logic        bus_cycle_tick,
  output logic             limit_output
);
  // word select by address
  function automatic logic sel(input logic [5:0] a, input logic [5:0] off);
    sel = (a[5:2] == off[5:2]);
  endfunction
  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  // synchronised pins
  logic [2:0]  pin_raw;       // count, gate input, bus tick
  logic [2:0]  pin_lvl;       // settled levels
  logic [2:0]  pin_rise;      // rising edges
  // software registers
  logic [5:0]  ctrl;          // mode and option bits
  logic [15:0] ppr;           // pulses per revolution
  logic [23:0] buscyc;        // bus cycle time in us
  logic [13:0] n_stage;       // staged window multiplier
  logic [31:0] low_stage;     // staged low limit
  logic [31:0] high_stage;    // staged high limit
  spm_outfn_t  outfn_stage;   // staged output function
  // active copies
  logic [13:0] n_act;         // window multiplier in use
  logic [31:0] low_act;       // low limit in use
  logic [31:0] high_act;      // high limit in use
  spm_outfn_t  outfn_act;     // output function in use
  // measurement state
  logic [17:0] base_cnt;      // 10 ms prescaler
  logic [13:0] win_cnt;       // units elapsed in window
  logic [5:0]  ref_acc;       // fractional reference phase
  logic        ref_tick;      // 16 MHz average tick
  logic [23:0] pulse_cnt;     // pulses this window
  logic [31:0] ref_cnt;       // reference ticks since edge
  logic        armed;         // a first edge has been seen
  logic [31:0] result;        // last measured value
  // bus state
  logic [31:0] rd_word;       // read mux output
  logic        rd_map;        // read hits a register
  logic        wr_map;        // write hits a register
  logic [31:0] wr_merged;     // write data after strobes
  logic [3:0]  cmd;           // load command pulses

  spm_div_if div ();

  // pin synchronisers
  assign pin_raw = {bus_cycle_tick, gate_capable_input, count_in};
  for (genvar g = 0; g < 3; g++) begin : g_sync
    spm_sync_edge u_sync (
      .clk   (aclk),
      .rst_n (aresetn),
      .d     (pin_raw[g]),
      .q     (pin_lvl[g]),
      .rise  (pin_rise[g])
    );
  end

  spm_divider u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .div     (div)
  );

  // ---- bus decode
  wire wr_go  = awvalid & wvalid & ~bvalid;  // aw and w taken together
  wire rd_go  = arvalid & ~rvalid;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign arready = rd_go;
  assign wr_map  = sel(awaddr, OFF_CTRL) | sel(awaddr, OFF_PPR) | sel(awaddr, OFF_BUSCYC)
                 | sel(awaddr, OFF_NSTAGE) | sel(awaddr, OFF_LOW) | sel(awaddr, OFF_HIGH)
                 | sel(awaddr, OFF_OUTFN) | sel(awaddr, OFF_CMD);
  // command word reads as zero, so merge over zero
  wire [31:0] wr_old = sel(awaddr, OFF_CTRL) ? {26'h0, ctrl} :
                       sel(awaddr, OFF_PPR) ? {16'h0, ppr} :
                       sel(awaddr, OFF_BUSCYC) ? {8'h0, buscyc} :
                       sel(awaddr, OFF_NSTAGE) ? {18'h0, n_stage} :
                       sel(awaddr, OFF_LOW) ? low_stage :
                       sel(awaddr, OFF_HIGH) ? high_stage :
                       sel(awaddr, OFF_OUTFN) ? {30'h0, outfn_stage} : 32'h0;
  assign wr_merged = merge(wr_old, wdata, wstrb);
  assign cmd = (wr_go && sel(awaddr, OFF_CMD)) ? wr_merged[3:0] : 4'h0;

  // ---- configuration checks
  wire        mode_period = ctrl[CTRL_PERIOD];
  wire [13:0] n_max       = mode_period ? PERIOD_N_MAX : SPEED_N_MAX;
  wire [37:0] n_prod      = 38'({24'h0, n_act} * {14'h0, buscyc});
  wire [37:0] iso_max     = mode_period ? PERIOD_ISO_US : SPEED_ISO_US;
  wire        range_err   = (n_act == 14'h0) | (n_act > n_max);
  // short cycles need n*T above 10 ms, long ones a capped n*T
  wire        iso_err     = ctrl[CTRL_ISO] & ((buscyc == 24'h0) |
                            ((buscyc < TIME_BASE_US) ? (n_prod <= ISO_MIN_US) : (n_prod > iso_max)));
  wire        param_error = range_err | iso_err;
  wire        iso_active  = ctrl[CTRL_ISO] & ~param_error;
  wire        run         = ctrl[CTRL_EN] & ~param_error;
  wire        gate_open   = ~ctrl[CTRL_GATE] | pin_lvl[1];
  wire        active      = run & gate_open;

  // ---- window timing
  wire base_tick = active & (base_cnt == 18'(BASE_CYC - 1));
  wire unit_tick = iso_active ? pin_rise[2] : base_tick;
  wire win_end   = active & unit_tick & (win_cnt >= 14'(n_act - 14'h1));
  wire cnt_rise  = active & pin_rise[0];
  wire per_cap   = mode_period & cnt_rise & armed;

  // prescaler, paused with the gate
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || base_tick || (mode_period && cnt_rise)) begin
      base_cnt <= 18'h0;  // an edge restarts the period window's unit too
    end else if (active) begin
      base_cnt <= 18'(base_cnt + 18'h1);
    end
  end

  // window counter; an edge restarts it in period mode
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || win_end || (mode_period && cnt_rise)) begin
      win_cnt <= 14'h0;
    end else if (active && unit_tick) begin
      win_cnt <= 14'(win_cnt + 14'h1);
    end
  end

  // 16 of every 20 clocks carry a reference tick
  wire [5:0] acc_sum = 6'(ref_acc + REF_STEP);
  assign ref_tick = acc_sum >= CLK_STEP;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_acc <= 6'h0;
    end else begin
      ref_acc <= ref_tick ? 6'(acc_sum - CLK_STEP) : acc_sum;
    end
  end

  // pulse accumulation for speed
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || win_end) begin
      pulse_cnt <= 24'h0;
    end else if (cnt_rise) begin
      pulse_cnt <= 24'(pulse_cnt + 24'h1);
    end
  end

  // reference count between edges; the edge cycle's own tick belongs to the period
  wire [31:0] ref_now = 32'(ref_cnt + {31'h0, ref_tick});
  always_ff @(posedge aclk) begin
    if (!aresetn || !active || cnt_rise) begin
      ref_cnt <= 32'h0;
      armed   <= aresetn & active & cnt_rise & mode_period;
    end else begin
      ref_cnt <= armed ? ref_now : ref_cnt;
      armed   <= armed & ~(win_end & mode_period);  // window out disarms, even on a tick
    end
  end

  // speed launch: pulses * 6e10 / (ppr * n * unit_us)
  wire [23:0] pulses_now = 24'(pulse_cnt + {23'h0, cnt_rise});
  wire [23:0] unit_us    = iso_active ? buscyc : TIME_BASE_US;
  assign div.start = win_end & ~mode_period & ~div.busy;
  assign div.num   = {40'h0, pulses_now} * {28'h0, SPEED_SCALE};
  assign div.den   = {48'h0, ppr} * {50'h0, n_act} * {40'h0, unit_us};

  // result register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= 32'h0;
    end else if (div.done && !mode_period) begin
      result <= div.quot;
    end else if (per_cap) begin
      result <= ctrl[CTRL_RES16] ? ref_now : {4'h0, ref_now[31:4]};
    end else if (win_end && mode_period && armed) begin
      result <= 32'h0;  // no second edge inside the window
    end
  end

  // ---- limits and output
  wire below = result < low_act;
  wire above = result > high_act;
  logic next_dout;
  always_comb begin
    unique case (outfn_act)
      OUT_PLAIN:   next_dout = ctrl[CTRL_DOUT];
      OUT_OUTSIDE: next_dout = below | above;
      OUT_BELOW:   next_dout = below;
      OUT_ABOVE:   next_dout = above;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_output <= 1'b0;
    end else begin
      limit_output <= next_dout;
    end
  end

  // ---- register writes and runtime loads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RST;
      ppr <= PPR_RST;
      buscyc <= BUSCYC_RST;
      n_stage <= N_RST;
      low_stage <= LOW_RST;
      high_stage <= HIGH_RST;
      outfn_stage <= OUT_PLAIN;
      n_act <= N_RST;
      low_act <= LOW_RST;
      high_act <= HIGH_RST;
      outfn_act <= OUT_PLAIN;
    end else begin
      if (wr_go && sel(awaddr, OFF_CTRL))   ctrl <= wr_merged[5:0];
      if (wr_go && sel(awaddr, OFF_PPR))    ppr <= wr_merged[15:0];
      if (wr_go && sel(awaddr, OFF_BUSCYC)) buscyc <= wr_merged[23:0];
      if (wr_go && sel(awaddr, OFF_NSTAGE)) n_stage <= wr_merged[13:0];
      if (wr_go && sel(awaddr, OFF_LOW))    low_stage <= wr_merged;
      if (wr_go && sel(awaddr, OFF_HIGH))   high_stage <= wr_merged;
      if (wr_go && sel(awaddr, OFF_OUTFN))  outfn_stage <= spm_outfn_t'(wr_merged[1:0]);
      // loads never stop measurement, except a window load that raises param_error
      if (cmd[CMD_LOW])   low_act <= low_stage;
      if (cmd[CMD_HIGH])  high_act <= high_stage;
      if (cmd[CMD_OUTFN]) outfn_act <= outfn_stage;
      if (cmd[CMD_WIN])   n_act <= n_stage;
    end
  end

  // ---- responses
  wire [31:0] status = {25'h0, above, below, gate_open, limit_output,
                        pin_lvl[1], iso_active, param_error};
  assign rd_word = sel(araddr, OFF_CTRL) ? {26'h0, ctrl} :
                   sel(araddr, OFF_PPR) ? {16'h0, ppr} :
                   sel(araddr, OFF_BUSCYC) ? {8'h0, buscyc} :
                   sel(araddr, OFF_NSTAGE) ? {18'h0, n_stage} :
                   sel(araddr, OFF_LOW) ? low_stage :
                   sel(araddr, OFF_HIGH) ? high_stage :
                   sel(araddr, OFF_OUTFN) ? {30'h0, outfn_stage} :
                   sel(araddr, OFF_RESULT) ? result :
                   sel(araddr, OFF_STATUS) ? status : 32'h0;
  assign rd_map  = sel(araddr, OFF_CTRL) | sel(araddr, OFF_PPR) | sel(araddr, OFF_BUSCYC)
                 | sel(araddr, OFF_NSTAGE) | sel(araddr, OFF_LOW) | sel(araddr, OFF_HIGH)
                 | sel(araddr, OFF_OUTFN) | sel(araddr, OFF_CMD) | sel(araddr, OFF_RESULT)
                 | sel(araddr, OFF_STATUS);

  // write answer held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_map ? RESP_OKAY : RESP_DECERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read answer held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_map ? RESP_OKAY : RESP_DECERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---- checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_speed_close;
    win_end && !mode_period && !div.busy;
  endsequence
  sequence s_div_answer;
    ##[64:66] div.done;
  endsequence

  speed_flow_a: assert property (s_speed_close |-> s_div_answer)
    else $error("speed window did not yield a division result");
  ref_rate_a: assert property (!ref_tick |=> ref_tick [*4])
    else $error("reference tick cadence is not 16 of 20");
  iso_block_a: assert property (param_error |-> !iso_active && !win_end)
    else $error("error present but iso or window active");
  gate_hold_a: assert property (!gate_open |=> $stable(pulse_cnt) && $stable(result))
    else $error("counting moved while gate closed");
  low_load_a: assert property (cmd[CMD_LOW] |=> low_act == $past(low_stage))
    else $error("low limit load not applied");
  win_load_a: assert property (cmd[CMD_WIN] |=> n_act == $past(n_stage))
    else $error("window multiplier load not applied");
  res_scale_a: assert property (per_cap && !ctrl[CTRL_RES16] |=> result == ($past(ref_now) >> 4))
    else $error("1 us period scaling wrong");
  below_out_a: assert property (outfn_act == OUT_BELOW && result < low_act |=> limit_output)
    else $error("output not set below low limit");
  win_tick_a: assert property (win_end && !iso_active |-> base_tick && win_cnt >= 14'(n_act - 14'h1))
    else $error("window closed off a 10 ms boundary");
  bus_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
endmodule

// file: rtl/spm_pkg.sv
// Purpose: constants and types shared by the speed and period measurement block
// Assumes: 20 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes:   every offset, field position, reset value and timing count lives here
package spm_pkg;
  // timing
  localparam int          CLK_HZ        = 20_000_000;        // system clock rate
  localparam int          TIME_BASE_MS  = 10;                // window unit off the bus
  localparam int          BASE_CYCLES   = CLK_HZ / 1000 * TIME_BASE_MS;
  localparam logic [23:0] TIME_BASE_US  = 24'h002710;        // 10 ms in us
  localparam int          REF_HZ        = 16_000_000;        // period reference
  localparam logic [5:0]  REF_STEP      = 6'(REF_HZ / 1_000_000);
  localparam logic [5:0]  CLK_STEP      = 6'(CLK_HZ / 1_000_000);
  // multiplier limits
  localparam logic [13:0] SPEED_N_MAX   = 14'h03e8;          // 1000
  localparam logic [13:0] PERIOD_N_MAX  = 14'h2ee0;          // 12000
  localparam logic [37:0] ISO_MIN_US    = 38'h0000002710;    // 10 ms
  localparam logic [37:0] SPEED_ISO_US  = 38'h0000989680;    // 10000 ms
  localparam logic [37:0] PERIOD_ISO_US = 38'h0007270e00;    // 120000 ms
  // 60 s/min * 1000 (milli) * 1e6 us/s
  localparam logic [35:0] SPEED_SCALE   = 36'hdf8475800;
  // register byte offsets
  localparam logic [5:0]  OFF_CTRL      = 6'h00;
  localparam logic [5:0]  OFF_PPR       = 6'h04;
  localparam logic [5:0]  OFF_BUSCYC    = 6'h08;
  localparam logic [5:0]  OFF_NSTAGE    = 6'h0c;
  localparam logic [5:0]  OFF_LOW       = 6'h10;
  localparam logic [5:0]  OFF_HIGH      = 6'h14;
  localparam logic [5:0]  OFF_OUTFN     = 6'h18;
  localparam logic [5:0]  OFF_CMD       = 6'h1c;
  localparam logic [5:0]  OFF_RESULT    = 6'h20;
  localparam logic [5:0]  OFF_STATUS    = 6'h24;
  // control fields
  localparam int          CTRL_EN       = 0;
  localparam int          CTRL_PERIOD   = 1;
  localparam int          CTRL_RES16    = 2;
  localparam int          CTRL_GATE     = 3;
  localparam int          CTRL_ISO      = 4;
  localparam int          CTRL_DOUT     = 5;
  // command fields
  localparam int          CMD_LOW       = 0;
  localparam int          CMD_HIGH      = 1;
  localparam int          CMD_OUTFN     = 2;
  localparam int          CMD_WIN       = 3;
  // status fields
  localparam int          ST_ERR        = 0;
  localparam int          ST_ISO        = 1;
  localparam int          ST_DIN        = 2;
  localparam int          ST_DOUT       = 3;
  localparam int          ST_GATE       = 4;
  localparam int          ST_BELOW      = 5;
  localparam int          ST_ABOVE      = 6;
  // reset values and bus response codes
  localparam logic [5:0]  CTRL_RST      = 6'h00;
  localparam logic [15:0] PPR_RST       = 16'h0001;
  localparam logic [23:0] BUSCYC_RST    = 24'h002710;
  localparam logic [13:0] N_RST         = 14'h0001;
  localparam logic [31:0] LOW_RST       = 32'h00000000;
  localparam logic [31:0] HIGH_RST      = 32'hffffffff;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_DECERR   = 2'b11;
  // limit output behaviours
  typedef enum logic [1:0] {
    OUT_PLAIN   = 2'b00,
    OUT_OUTSIDE = 2'b01,
    OUT_BELOW   = 2'b10,
    OUT_ABOVE   = 2'b11
  } spm_outfn_t;
  // divider states
  typedef enum logic {
    DIV_IDLE = 1'b0,
    DIV_RUN  = 1'b1
  } spm_div_state_t;
endpackage

// file: rtl/spm_div_if.sv
// Purpose: request and answer bundle between measurement core and divider
// Assumes: one division at a time, start only while idle
// Notes:   quot is saturated to 32 bits by the divider
`timescale 1ns/100ps
interface spm_div_if;
  logic        start;  // one-cycle launch
  logic [63:0] num;    // dividend, valid with start
  logic [63:0] den;    // divisor, valid with start
  logic        busy;   // division under way
  logic        done;   // one-cycle, quot valid
  logic [31:0] quot;   // saturated quotient
  modport req (output start, num, den, input busy, done, quot);
  modport dvd (input start, num, den, output busy, done, quot);
endinterface

// file: rtl/spm_sync_edge.sv
// Purpose: two-flop synchroniser with rising-edge detect for a pin
// Assumes: pin is asynchronous to clk
// Notes:   first flop feeds only the second one
`timescale 1ns/100ps
module spm_sync_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin side
  input  wire logic d,
  // synchronised side
  output logic      q,
  output logic      rise
);
  logic s1;  // metastable stage
  logic s2;  // settled level
  logic s3;  // previous settled level

  // shift chain, reset to constants
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign q    = s2;
  assign rise = s2 & ~s3;
endmodule

// file: rtl/spm_divider.sv
// Purpose: 64 by 64 restoring divider, one quotient bit per clock
// Assumes: start only while busy is low
// Notes:   zero divisor yields all ones, which saturates
`timescale 1ns/100ps
module spm_divider import spm_pkg::*; (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // request and answer
  spm_div_if.dvd    div
);
  spm_div_state_t state;   // idle or running
  logic [63:0]    q;       // dividend shifting into quotient
  logic [63:0]    r;       // partial remainder
  logic [63:0]    d;       // held divisor
  logic [5:0]     cnt;     // bit index
  logic [64:0]    r_sh;    // remainder with next dividend bit
  logic           fits;    // subtraction succeeds
  logic [63:0]    next_r;  // remainder after step
  logic [63:0]    next_q;  // quotient after step

  assign r_sh   = {r, q[63]};
  assign fits   = r_sh >= {1'b0, d};
  assign next_r = fits ? 64'(r_sh - {1'b0, d}) : r_sh[63:0];
  assign next_q = {q[62:0], fits};
  assign div.busy = (state == DIV_RUN);

  // sequencing and result capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= DIV_IDLE;
      q        <= 64'h0;
      r        <= 64'h0;
      d        <= 64'h0;
      cnt      <= 6'h00;
      div.done <= 1'b0;
      div.quot <= 32'h00000000;
    end else begin
      div.done <= 1'b0;
      unique case (state)
        DIV_IDLE: begin
          if (div.start) begin
            q     <= div.num;
            r     <= 64'h0;
            d     <= div.den;
            cnt   <= 6'h00;
            state <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          q   <= next_q;
          r   <= next_r;
          cnt <= 6'(cnt + 6'h01);
          if (cnt == 6'h3f) begin
            // results beyond 32 bits clamp rather than wrap
            div.quot <= (|next_q[63:32]) ? 32'hffffffff : next_q[31:0];
            div.done <= 1'b1;
            state    <= DIV_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// file: testbench/spm_enc_model.sv
// Purpose: encoder model driving square pulses on the counting pin
// Assumes: pulse period is twice half_cyc clocks
// Notes:   steady period keeps counts per window exact
`timescale 1ns/100ps
module spm_enc_model (
  // clock
  input  wire logic       clk,
  // control
  input  wire logic       run,
  input  wire logic [7:0] half_cyc,
  // pin
  output logic            pulse
);
  logic [7:0] cnt;  // cycles in this half
  // toggle each half period, low while stopped
  always_ff @(posedge clk) begin
    if (!run) begin
      cnt   <= 8'h00;
      pulse <= 1'b0;
    end else if (cnt == half_cyc - 8'h01) begin
      cnt   <= 8'h00;
      pulse <= ~pulse;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// file: testbench/tb_top.sv
// Purpose: self-checking bench for the speed and period block
// Assumes: window unit cut to 80 clocks, pulse period 20 clocks (1 us)
// Notes:   each unit then holds exactly 4 pulses
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top import spm_pkg::*;;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, count_in;
  logic        gate_capable_input, limit_output;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  int          error_cnt, n_checks;
  logic        bus_tick = 1'b0;  // isochronous unit pin, 160 clocks a cycle
  // reset values, last row unmapped
  logic [5:0]  row_addr [9] = '{OFF_CTRL, OFF_PPR, OFF_BUSCYC, OFF_NSTAGE, OFF_LOW,
                                OFF_HIGH, OFF_OUTFN, OFF_CMD, 6'h28};
  logic [31:0] row_data [9] = '{32'(CTRL_RST), 32'(PPR_RST), 32'(BUSCYC_RST), 32'(N_RST),
                                LOW_RST, HIGH_RST, 32'h0, 32'h0, 32'h0};
  logic        fn_exp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};  // 6e6 vs high 5e6
  spm_top #(.BASE_CYC(80)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .count_in, .gate_capable_input,
    .bus_cycle_tick(bus_tick), .limit_output);
  spm_enc_model enc (.clk(aclk), .run(aresetn), .half_cyc(8'h0a), .pulse(count_in));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // bus cycle pin toggles off the clock edge
  always begin
    repeat (80) @(posedge aclk);
    bus_tick <= ~bus_tick;
  end
  // bready raised only after the take, so no double drive at re-entry
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    // each channel held until its own ready
    fork
      begin
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    bready  <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready  <= 1'b0;
    resp = bresp;
  endtask
  task automatic rd(input logic [5:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready  <= 1'b0;
    rd_val = rdata;
    resp   = rresp;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // a hang costs one mismatch
  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    summarize();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 48'h0;
    gate_capable_input = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 9; i++) begin
      rd(row_addr[i]);
      `CHK("reg", row_data[i], rd_val)
      `CHK("rresp", (i == 8) ? RESP_DECERR : RESP_OKAY, resp)
    end
    wr(6'h28, 32'h1);
    `CHK("bresp", RESP_DECERR, resp)
    $display("test registers done");
    // 4 pulses * 6e10 / (ppr 4 * 10000 us) = 6e6
    wr(OFF_PPR, 32'h4);
    wr(OFF_CTRL, 32'h1);
    repeat (400) @(posedge aclk);
    rd(OFF_RESULT);
    `CHK("speed", 32'h005b8d80, rd_val)
    $display("test speed done");
    wr(OFF_HIGH, 32'h004c4b40);  // 5e6, inside controller range
    wr(OFF_CMD, 32'h2);
    for (int f = 0; f < 4; f++) begin
      wr(OFF_OUTFN, 32'(f));
      repeat (3) @(posedge aclk);
      if (f > 0) `CHK("staged", fn_exp[f-1], limit_output)
      wr(OFF_CMD, 32'h4);
      repeat (3) @(posedge aclk);
      `CHK("outfn", fn_exp[f], limit_output)
    end
    $display("test output done");
    gate_capable_input <= 1'b0;
    wr(OFF_CTRL, 32'h9);
    wr(OFF_PPR, 32'h8);  // a window leaking past the gate would give 3e6
    repeat (300) @(posedge aclk);
    rd(OFF_RESULT);
    `CHK("gate hold", 32'h005b8d80, rd_val)
    rd(OFF_STATUS);
    `CHK("din", 1'b0, rd_val[ST_DIN])
    gate_capable_input <= 1'b1;
    $display("test gate done");
    for (int i = 0; i < 2; i++) begin
      wr(OFF_NSTAGE, i ? 32'h3e8 : 32'h3e9);  // just past, then at, the ceiling
      wr(OFF_CMD, 32'h8);
      rd(OFF_STATUS);
      `CHK("param err", i ? 1'b0 : 1'b1, rd_val[ST_ERR])
    end
    $display("test multiplier done");
    // 20 ms cycle with n 1000 breaks the iso ceiling
    wr(OFF_BUSCYC, 32'h4e20);
    wr(OFF_CTRL, 32'h11);
    rd(OFF_STATUS);
    `CHK("iso err", 2'b01, rd_val[ST_ISO:ST_ERR])
    wr(OFF_BUSCYC, 32'h2710);
    wr(OFF_NSTAGE, 32'h1);
    wr(OFF_CMD, 32'h8);
    repeat (500) @(posedge aclk);
    rd(OFF_STATUS);
    `CHK("iso on", 2'b10, rd_val[ST_ISO:ST_ERR])
    // 8 pulses per 160-clock bus cycle, ppr 8, unit 10000 us
    rd(OFF_RESULT);
    `CHK("iso speed", 32'h005b8d80, rd_val)
    $display("test iso done");
    // 20 clocks = 1 us: 16 sixteenths, or 1 us
    for (int i = 0; i < 2; i++) begin
      wr(OFF_CTRL, i ? 32'h3 : 32'h7);
      repeat (300) @(posedge aclk);
      rd(OFF_RESULT);
      `CHK("period", i ? 32'h1 : 32'h10, rd_val)
    end
    wr(OFF_LOW, 32'h2);  // inside the 1 us low range
    wr(OFF_OUTFN, 32'h2);
    wr(OFF_CMD, 32'h5);
    repeat (3) @(posedge aclk);
    `CHK("period below", 1'b1, limit_output)
    wr(OFF_CTRL, 32'h7);  // same limits, inside the 1/16 us ranges
    repeat (60) @(posedge aclk);
    `CHK("period 1/16", 1'b0, limit_output)
    $display("test period done");
    summarize();
  end
endmodule
